/* File: hw/scc_cfg.svh */
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH

// system clock period in ns (25 MHz)
`define SCC_CLK_PERIOD_NS   40
// conversion time in ns
`define SCC_CONV_TIME_NS    3000
// conversion cycles, rounded down, not clamped to one
`define SCC_CONV_CYCLES     (`SCC_CONV_TIME_NS / `SCC_CLK_PERIOD_NS)
// conversion clock divider: one enable pulse per this many system cycles
`define SCC_CCLK_DIV        5
// conversion clock ticks per conversion
`define SCC_CONV_TICKS      (`SCC_CONV_CYCLES / `SCC_CCLK_DIV)

// register offsets (byte addresses)
`define SCC_REG_CTRL        8'h00
`define SCC_REG_STATUS      8'h04
`define SCC_REG_INT_STAT    8'h08
`define SCC_REG_INT_EN      8'h0c
`define SCC_REG_INT_CLR     8'h10

// control register fields
`define SCC_CTRL_RNG_LSB    0
`define SCC_CTRL_BUFDIS_BIT 8
`define SCC_CTRL_REFEN_BIT  9
`define SCC_CTRL_RESET      32'h0000_0000

// interrupt status bits: [2:0] end of conversion per pair, [5:3] start ignored
`define SCC_INT_EOC_LSB     0
`define SCC_INT_IGN_LSB     3
`define SCC_INT_WIDTH       6

// code width of the result path
`define SCC_CODE_W          16

`endif

/* File: hw/scc_pkg.sv */
package scc_pkg;

  typedef enum logic [1:0] {
    SCC_RES_16 = 2'h0,
    SCC_RES_14 = 2'h1,
    SCC_RES_12 = 2'h2
  } scc_res_type;

  typedef enum logic {
    SCC_RANGE_4X = 1'b0,
    SCC_RANGE_2X = 1'b1
  } scc_range_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } scc_bus_req_type;

  typedef struct packed {
    logic [2:0]     hold;
    logic [2:0]     busy;
    scc_range_type [2:0] range;
  } scc_pair_stat_type;

endpackage : scc_pkg

/* File: hw/scc_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module scc_sync
  import scc_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk_sys_in,
  input  wire logic             rst_b_in,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;

  // first stage is read by the second stage only
  // resets high: start pins idle high, so release shows no false edge
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      meta_ff  <= '1;
      sync_out <= '1;
    end
    else
    begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule // scc_sync

`default_nettype wire

/* File: hw/scc_pair.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scc_cfg.svh"

module scc_pair
  import scc_pkg::*;
(
  input  wire logic          clk_sys_in,
  input  wire logic          rst_b_in,
  input  wire logic          cclk_en_in,
  input  wire logic          start_in,
  input  wire scc_range_type range_in,
  input  wire logic          ref_ok_in,
  input  wire logic [15:0]   sample_a_in,
  input  wire logic [15:0]   sample_b_in,
  output var  logic          hold_out,
  output var  logic          done_out,
  output var  logic          ignored_out,
  output var  scc_range_type range_out,
  output var  logic [15:0]   held_a_out,
  output var  logic [15:0]   held_b_out
);

  logic [7:0] tick_ff;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      hold_out    <= 1'b0;
      done_out    <= 1'b0;
      ignored_out <= 1'b0;
      tick_ff     <= 8'h00;
      range_out   <= SCC_RANGE_4X;
      held_a_out  <= 16'h0000;
      held_b_out  <= 16'h0000;
    end
    else
    begin
      done_out    <= 1'b0;
      ignored_out <= start_in && hold_out;
      if (start_in && !hold_out)
      begin
        hold_out   <= 1'b1;
        tick_ff    <= 8'h00;
        range_out  <= range_in;
        held_a_out <= sample_a_in;
        held_b_out <= sample_b_in;
      end
      else if (hold_out && cclk_en_in && ref_ok_in)
      begin
        if (tick_ff == 8'(`SCC_CONV_TICKS - 1))
        begin
          hold_out <= 1'b0;
          done_out <= 1'b1;
        end
        else
        begin
          tick_ff <= tick_ff + 8'h01;
        end
      end
    end
  end

endmodule // scc_pair

`default_nettype wire

/* File: hw/scc_top.sv */
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "scc_cfg.svh"

module scc_top
  import scc_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  input  wire logic [2:0]  conversion_start_in,
  input  wire logic        range_pin_in,
  input  wire logic        hw_sw_sel_in,
  input  wire logic        serial_sel_in,
  input  wire logic        internal_ref_enable_pin_in,
  input  wire logic        ref_buffer_disable_pin_in,
  input  wire scc_res_type resolution_in,
  input  wire logic [15:0] analog_in [6],
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  output logic             busy_out,
  output logic [2:0]       pair_hold_out,
  output logic             int_ref_on_out,
  output logic [2:0]       ref_buf_on_out,
  output logic             irq_out,
  output logic [15:0]      result_out [6]
);

  logic [2:0]  start_sync;
  logic        range_sync;
  logic        hwsw_sync;
  logic        ser_sync;
  logic        refen_sync;
  logic        bufdis_sync;
  logic [2:0]  start_dly_ff;
  logic [2:0]  start_rise;
  logic [2:0]  pair_hold;
  logic [2:0]  pair_done;
  logic [2:0]  pair_ign;
  scc_range_type pair_range [3];
  logic [15:0] held [6];
  logic [2:0]  div_ff;
  logic        cclk_en_ff;
  logic [31:0] ctrl_ff;
  logic [`SCC_INT_WIDTH-1:0] int_stat_ff;
  logic [`SCC_INT_WIDTH-1:0] int_en_ff;
  logic [`SCC_INT_WIDTH-1:0] nxt_int_stat;
  logic [`SCC_INT_WIDTH-1:0] int_set;
  logic [`SCC_INT_WIDTH-1:0] int_clr;
  scc_bus_req_type bus;
  scc_range_type eff_range [3];

  assign bus = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};

  // pin inputs pass two flops before use
  scc_sync #(.WIDTH(8)) u_sync
  (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .async_in   ({conversion_start_in, range_pin_in, hw_sw_sel_in, serial_sel_in,
                  internal_ref_enable_pin_in, ref_buffer_disable_pin_in}),
    .sync_out   ({start_sync, range_sync, hwsw_sync, ser_sync, refen_sync, bufdis_sync})
  );

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
      start_dly_ff <= 3'h7;
    else
      start_dly_ff <= start_sync;
  end

  assign start_rise = start_sync & ~start_dly_ff;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      div_ff     <= 3'h0;
      cclk_en_ff <= 1'b0;
    end
    else
    begin
      cclk_en_ff <= (div_ff == 3'(`SCC_CCLK_DIV - 1));
      div_ff     <= (div_ff == 3'(`SCC_CCLK_DIV - 1)) ? 3'h0 : div_ff + 3'h1;
    end
  end

  // range pin in hardware mode, pair bits in software
  always_comb
  begin
    for (int p = 0; p < 3; p++)
      eff_range[p] = hwsw_sync ? scc_range_type'(ctrl_ff[`SCC_CTRL_RNG_LSB + p])
                               : scc_range_type'(range_sync);
  end

  // pair p owns channels 2p and 2p+1
  for (genvar p = 0; p < 3; p++)
  begin : g_pair
    scc_pair u_pair
    (
      .clk_sys_in  (clk_sys_in),
      .rst_b_in    (rst_b_in),
      .cclk_en_in  (cclk_en_ff),
      .start_in    (start_rise[p]),
      .range_in    (eff_range[p]),
      .ref_ok_in   (1'b1),
      .sample_a_in (analog_in[2*p]),
      .sample_b_in (analog_in[2*p+1]),
      .hold_out    (pair_hold[p]),
      .done_out    (pair_done[p]),
      .ignored_out (pair_ign[p]),
      .range_out   (pair_range[p]),
      .held_a_out  (held[2*p]),
      .held_b_out  (held[2*p+1])
    );
  end

  // lsb weight from resolution; keep only significant bits
  function automatic logic [15:0] scc_code(input logic [15:0] raw, input scc_res_type res);
    logic [15:0] c;
    c = raw;
    unique case (res)
      SCC_RES_16: c = raw;
      SCC_RES_14: c = {{2{raw[15]}}, raw[15:2]};
      SCC_RES_12: c = {{4{raw[15]}}, raw[15:4]};
      default:    c = raw;
    endcase
    return c;
  endfunction

  // signed twos complement, sample already quantised at half-lsb points
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      for (int i = 0; i < 6; i++)
        result_out[i] <= 16'h0000;
    end
    else
    begin
      for (int i = 0; i < 6; i++)
        if (pair_done[i/2])
          result_out[i] <= scc_code(held[i], resolution_in);
    end
  end

  // busy while any pair converts; holds drop at end
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      busy_out      <= 1'b0;
      pair_hold_out <= 3'h0;
    end
    else
    begin
      busy_out      <= |(pair_hold | start_rise) && !(&(~pair_hold | pair_done) && !(|start_rise));
      pair_hold_out <= (pair_hold & ~pair_done) | start_rise;
    end
  end

  // reset gives external reference, buffers on
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      int_ref_on_out <= 1'b0;
      ref_buf_on_out <= 3'h7;
    end
    else
    begin
      int_ref_on_out <= hwsw_sync ? ctrl_ff[`SCC_CTRL_REFEN_BIT] : refen_sync;
      if (hwsw_sync)
        ref_buf_on_out <= {3{~ctrl_ff[`SCC_CTRL_BUFDIS_BIT]}};
      else
        ref_buf_on_out <= {3{~(ser_sync && bufdis_sync)}};
    end
  end

  // control register write
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
      ctrl_ff <= `SCC_CTRL_RESET;
    else if (bus.wr && bus.addr == `SCC_REG_CTRL)
      ctrl_ff <= bus.wdata & 32'h0000_0307;
  end

  // interrupt: set wins over clear
  assign int_set = {pair_ign, pair_done};
  assign int_clr = (bus.wr && bus.addr == `SCC_REG_INT_CLR) ? bus.wdata[`SCC_INT_WIDTH-1:0]
                                                            : '0;
  assign nxt_int_stat = (int_stat_ff & ~int_clr) | int_set;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      int_stat_ff <= '0;
      int_en_ff   <= '0;
      irq_out     <= 1'b0;
    end
    else
    begin
      int_stat_ff <= nxt_int_stat;
      if (bus.wr && bus.addr == `SCC_REG_INT_EN)
        int_en_ff <= bus.wdata[`SCC_INT_WIDTH-1:0];
      irq_out <= |(nxt_int_stat & ((bus.wr && bus.addr == `SCC_REG_INT_EN)
                                   ? bus.wdata[`SCC_INT_WIDTH-1:0] : int_en_ff));
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (bus.rd)
    begin
      unique case (bus.addr)
        `SCC_REG_CTRL:     reg_rdata_out <= ctrl_ff;
        `SCC_REG_STATUS:   reg_rdata_out <= {20'h00000, 1'b0, int_ref_on_out, ref_buf_on_out,
                                             pair_range[2], pair_range[1], pair_range[0],
                                             busy_out, pair_hold};
        `SCC_REG_INT_STAT: reg_rdata_out <= {26'h0000000, int_stat_ff};
        `SCC_REG_INT_EN:   reg_rdata_out <= {26'h0000000, int_en_ff};
        default:           reg_rdata_out <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata_out <= 32'h0000_0000;
  end

  AST_BUSY_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    busy_out == |pair_hold_out)
    else $error("busy does not match held pairs");

  // start on busy pair is ignored
  AST_IGNORE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (start_rise[0] && pair_hold[0]) |=> pair_ign[0])
    else $error("start on busy pair not flagged");

  AST_RESET_REF: assert property (@(posedge clk_sys_in)
    !rst_b_in |=> (!int_ref_on_out && ref_buf_on_out == 3'h7))
    else $error("reference reset state wrong");

  AST_SW_REF: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    hwsw_sync |=> int_ref_on_out == $past(ctrl_ff[`SCC_CTRL_REFEN_BIT]))
    else $error("software reference enable not applied");

  AST_SW_BUF: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (hwsw_sync && ctrl_ff[`SCC_CTRL_BUFDIS_BIT]) |=> ref_buf_on_out == 3'h0)
    else $error("buffers not disabled by software");

  AST_HW_BUF: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (!hwsw_sync && ser_sync && bufdis_sync) |=> ref_buf_on_out == 3'h0)
    else $error("buffers not disabled by pin");

  sequence s_start0;
    start_rise[0] && !pair_hold[0];
  endsequence
  AST_CONV_TIME: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    s_start0 |=> pair_hold[0] [*8] ##[64:68] pair_done[0])
    else $error("conversion time wrong");

  AST_TRACK: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    pair_done[1] |-> !pair_hold[1])
    else $error("pair still held after done");

  AST_RANGE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (start_rise[2] && !pair_hold[2]) |=> pair_range[2] == $past(eff_range[2]))
    else $error("range not taken at start");

  AST_START_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (start_rise[1] && !pair_hold[1]) |=> pair_hold[1])
    else $error("started pair not held");

  // a start input holds its own pair only
  AST_PAIR_MAP: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (pair_hold == 3'h0 && start_rise == 3'h4) |=> pair_hold == 3'h4)
    else $error("start reached the wrong pair");

  // busy falls only once every pair tracks
  AST_BUSY_FALL: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $fell(busy_out) |-> pair_hold == 3'h0)
    else $error("busy fell while a pair holds");

  AST_IGN_FLAG: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    pair_ign[0] |=> int_stat_ff[`SCC_INT_IGN_LSB])
    else $error("ignored start not recorded");

  AST_DONE_FLAG: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    pair_done[2] |=> int_stat_ff[`SCC_INT_EOC_LSB + 2])
    else $error("end of conversion not recorded");

  // results stand until the pair converts again
  AST_RESULT_STABLE: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !pair_done[1] |=> $stable(result_out[2]))
    else $error("result changed without a conversion");

  // hardware mode follows the reference pin
  AST_HW_REF: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !hwsw_sync |=> int_ref_on_out == $past(refen_sync))
    else $error("hardware reference enable not applied");

  // in hardware mode, buffers stay on unless serial select and the buffer disable pin are both high
  AST_HW_BUF_ON: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (!hwsw_sync && !(ser_sync && bufdis_sync)) |=> ref_buf_on_out == 3'h7)
    else $error("buffers off without a disable");

endmodule // scc_top

`default_nettype wire

/* File: bench/scc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module scc_host_model
  import scc_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       go_in,
  input  wire logic [2:0] mask_in,
  input  wire logic [3:0] low_len_in,
  output var  logic [2:0] conversion_start_out
);
  logic [3:0] low_cnt_ff;

  initial
  begin
    conversion_start_out = 3'h7;
    low_cnt_ff           = 4'h0;
  end

  // fall then rise
  // pins idle high: only the return to high may start a pair
  always @(posedge clk_sys_in)
  begin
    if (go_in)
    begin
      conversion_start_out <= ~mask_in;
      low_cnt_ff           <= low_len_in;
    end
    else if (low_cnt_ff != 4'h0)
      low_cnt_ff <= low_cnt_ff - 4'h1;
    else
      conversion_start_out <= 3'h7;
  end
endmodule // scc_host_model

`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench
  import scc_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst_b   = 1'b0;
  logic        rng_pin = 1'b0;
  logic        hw_sw   = 1'b0;
  logic        ser_sel = 1'b0;
  logic        iref_pin = 1'b0;
  logic        buf_pin = 1'b0;
  scc_res_type res     = SCC_RES_16;
  logic [15:0] analog [6];
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        go      = 1'b0;
  logic [2:0]  mask    = 3'h0;
  logic [3:0]  low_len = 4'h0;
  logic [31:0] rdata;
  logic        busy, irq, iref_on;
  logic [2:0]  hold, buf_on, starts;
  logic [15:0] result [6];
  int          failures = 0;
  int          n_compared = 0;
  int          n;

  initial
  begin
    for (int i = 0; i < 6; i++)
      analog[i] = 16'h8004 + 16'h2222 * 16'(i);
    forever #20 clk_sys = ~clk_sys;
  end

  scc_host_model host_u (.clk_sys_in(clk_sys), .go_in(go), .mask_in(mask),
    .low_len_in(low_len), .conversion_start_out(starts));

  scc_top dut_u (.clk_sys_in(clk_sys), .rst_b_in(rst_b), .conversion_start_in(starts),
    .range_pin_in(rng_pin), .hw_sw_sel_in(hw_sw), .serial_sel_in(ser_sel),
    .internal_ref_enable_pin_in(iref_pin), .ref_buffer_disable_pin_in(buf_pin),
    .resolution_in(res), .analog_in(analog), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .busy_out(busy),
    .pair_hold_out(hold), .int_ref_on_out(iref_on), .ref_buf_on_out(buf_on),
    .irq_out(irq), .result_out(result));

  task automatic give_verdict;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask

  task automatic start(input logic [2:0] m, input logic [3:0] l);
    @(posedge clk_sys);
    go <= 1'b1;
    mask <= m;
    low_len <= l;
    @(posedge clk_sys);
    go <= 1'b0;
  endtask

  // bounded wait, the level reached is itself compared
  task automatic wait_hold(input int p, input logic v);
    n = 0;
    #1;
    while (hold[p] !== v && n < 120)
    begin
      cyc(1);
      n++;
    end
    chk(32'(hold[p]), 32'(v));
  endtask

  task automatic t_reset;
    chk({busy, hold, iref_on, buf_on, irq}, {23'h0, 9'h00e});
    rd_chk(8'h00, 32'h0);
  endtask

  task automatic t_single;
    for (int p = 0; p < 3; p++)
    begin
      start(3'(1 << p), (p == 2) ? 4'hc : 4'h0);
      wait_hold(p, 1'b1);
      chk(32'(n >= ((p == 2) ? 12 : 1)), 32'h1);
      chk(32'(hold), 32'(1 << p));
      chk(32'(busy), 32'h1);
      wait_hold(p, 1'b0);
      chk(32'(n >= 70 && n <= 76), 32'h1);
      chk(32'(result[2 * p]), 32'(analog[2 * p]));
      chk(32'(result[2 * p + 1]), 32'(analog[2 * p + 1]));
      cyc(1);
      chk(32'(busy), 32'h0);
    end
    rd_chk(8'h08, 32'h07);
    reg_wr(8'h10, 32'h3f);
    rd_chk(8'h08, 32'h0);
  endtask

  // second start on a busy pair comes with a start on another pair
  task automatic t_overlap;
    start(3'h1, 4'h0);
    wait_hold(0, 1'b1);
    start(3'h3, 4'h1);
    wait_hold(1, 1'b1);
    wait_hold(0, 1'b0);
    cyc(1);
    chk(32'(busy), 32'h1);
    wait_hold(1, 1'b0);
    cyc(1);
    chk(32'(busy), 32'h0);
    rd_chk(8'h08, 32'h0b);
    reg_wr(8'h10, 32'h3f);
  endtask

  task automatic t_res;
    logic [15:0] e;
    for (int k = 1; k < 3; k++)
    begin
      @(posedge clk_sys) res <= scc_res_type'(k);
      start(3'h1, 4'h0);
      wait_hold(0, 1'b1);
      wait_hold(0, 1'b0);
      e = 16'($signed(analog[0]) >>> (2 * k));
      chk(32'(result[0]), 32'(e));
    end
    @(posedge clk_sys) res <= SCC_RES_16;
  endtask

  task automatic t_ref;
    @(posedge clk_sys) hw_sw <= 1'b1;
    reg_wr(8'h00, 32'h0305);
    cyc(5);
    chk({iref_on, buf_on}, 32'h8);
    start(3'h7, 4'h0);
    wait_hold(2, 1'b1);
    rd_chk(8'h04, 32'h45f);
    wait_hold(2, 1'b0);
    rd_chk(8'h20, 32'h0);
    reg_wr(8'h00, 32'h0);
    reg_wr(8'h10, 32'h3f);
    @(posedge clk_sys);
    hw_sw <= 1'b0;
    iref_pin <= 1'b1;
    ser_sel <= 1'b1;
    buf_pin <= 1'b1;
    cyc(6);
    chk({iref_on, buf_on}, 32'h8);
    @(posedge clk_sys) ser_sel <= 1'b0;
    cyc(6);
    chk(32'(buf_on), 32'h7);
    // external reference in use again, so the internal one goes off
    @(posedge clk_sys) iref_pin <= 1'b0;
    cyc(6);
    chk(32'(iref_on), 32'h0);
  endtask

  task automatic t_irq;
    @(posedge clk_sys) rng_pin <= 1'b1;
    reg_wr(8'h0c, 32'h01);
    start(3'h2, 4'h0);
    wait_hold(1, 1'b1);
    wait_hold(1, 1'b0);
    cyc(2);
    chk(32'(irq), 32'h0);
    rd_chk(8'h04, 32'h3f0);
    reg_wr(8'h0c, 32'h3f);
    cyc(2);
    chk(32'(irq), 32'h1);
    rd_chk(8'h0c, 32'h3f);
    reg_wr(8'h10, 32'h3f);
    cyc(2);
    chk(32'(irq), 32'h0);
    rd_chk(8'h08, 32'h0);
  endtask

  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    cyc(3);
    t_reset();
    t_single();
    t_overlap();
    t_res();
    t_ref();
    t_irq();
    give_verdict();
  end

  // whole run needs about 800 cycles
  initial
  begin
    #(40 * 20000);
    failures++;
    give_verdict();
  end
endmodule // testbench

`default_nettype wire
